// File: hw/slx_pkg.sv
// Package: register map, field layout and reset values of the crossbar
package slx_pkg;

  // Register port widths
  localparam int SLX_ADDR_W = 12;
  localparam int SLX_DATA_W = 8;

  // Physical and logical lane counts
  localparam int SLX_PHYS_N = 8;
  localparam int SLX_LOG_N = 4;
  localparam int SLX_SEL_W = 3;

  // Register byte addresses
  localparam logic [11:0] SLX_MAP_FOUR_FIVE_ADDR = 12'h30A;
  localparam logic [11:0] SLX_MAP_SIX_SEVEN_ADDR = 12'h30B;
  localparam logic [11:0] SLX_FIFO_FULL_ADDR = 12'h30C;
  localparam logic [11:0] SLX_FIFO_EMPTY_ADDR = 12'h30D;
  localparam logic [11:0] SLX_FULL_EVT_STAT_ADDR = 12'h320;
  localparam logic [11:0] SLX_FULL_EVT_MASK_ADDR = 12'h321;
  localparam logic [11:0] SLX_EMPTY_EVT_STAT_ADDR = 12'h322;
  localparam logic [11:0] SLX_EMPTY_EVT_MASK_ADDR = 12'h323;

  // Field positions inside a crossbar register
  localparam int SLX_LO_SEL_LSB = 0;
  localparam int SLX_HI_SEL_LSB = 3;

  // Select reset values
  localparam logic [2:0] SLX_SEL4_RST = 3'h4;
  localparam logic [2:0] SLX_SEL5_RST = 3'h5;
  localparam logic [2:0] SLX_SEL6_RST = 3'h6;
  localparam logic [2:0] SLX_SEL7_RST = 3'h7;

  // Status, event and mask reset values
  localparam logic [7:0] SLX_STAT_RST = 8'h00;
  localparam logic [7:0] SLX_MASK_RST = 8'h00;

  // Read value of unmapped addresses and idle read cycles
  localparam logic [7:0] SLX_RD_IDLE = 8'h00;

endpackage

// File: hw/slx_lane_mux.sv
// One logical lane: registered eight-to-one physical lane selector
module slx_lane_mux #(
  parameter int LANE_W = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [slx_pkg::SLX_SEL_W-1:0] i_sel,
  input wire logic [slx_pkg::SLX_PHYS_N*LANE_W-1:0] i_data,
  input wire logic [slx_pkg::SLX_PHYS_N-1:0] i_valid,
  output logic [LANE_W-1:0] o_data,
  output logic o_valid
);
  import slx_pkg::*;

  logic [LANE_W-1:0] lane_w [SLX_PHYS_N];
  logic [LANE_W-1:0] data_d;
  logic valid_d;

  // Unpack the flat physical bus into lanes
  for (genvar g = 0; g < SLX_PHYS_N; g++) begin : g_unpack
    assign lane_w[g] = i_data[g*LANE_W +: LANE_W];
  end

  // Select value n takes physical input n
  assign data_d = lane_w[i_sel];
  assign valid_d = i_valid[i_sel];

  // Register the selected lane so the output comes from a flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= '0;
      o_valid <= 1'b0;
    end else begin
      o_data <= data_d;
      o_valid <= valid_d;
    end
  end

endmodule

// File: hw/slx_crossbar_upper.sv
// Top: upper logical-lane crossbar, lane FIFO status and event interrupt
//
// Operation
// - Three-bit select n routes physical input n
// - Lane four select, bits 2:0, 0x30A, reset 4
// - Lane five select, upper field, reset 5
// - Lane six select, bits 2:0, 0x30B, reset 6
// - Lane seven select, bits 5:3, reset 7
// - FIFO full status at 0x30C, resets zero
// - FIFO empty status at 0x30D, read only
//
// The plain strobed port was left to the implementer.
module slx_crossbar_upper #(
  parameter int LANE_W = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [slx_pkg::SLX_ADDR_W-1:0] i_addr,
  input wire logic [slx_pkg::SLX_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [slx_pkg::SLX_DATA_W-1:0] o_rdata,
  // Deserialised physical lanes
  input wire logic [slx_pkg::SLX_PHYS_N*LANE_W-1:0] i_phys_data,
  input wire logic [slx_pkg::SLX_PHYS_N-1:0] i_phys_valid,
  // Lane FIFO flags, one per physical input
  input wire logic [slx_pkg::SLX_PHYS_N-1:0] i_fifo_full,
  input wire logic [slx_pkg::SLX_PHYS_N-1:0] i_fifo_empty,
  // Logical lanes four to seven, lane four in the low slice
  output logic [slx_pkg::SLX_LOG_N*LANE_W-1:0] o_log_data,
  output logic [slx_pkg::SLX_LOG_N-1:0] o_log_valid,
  // Level interrupt
  output logic o_irq
);
  import slx_pkg::*;

  // Address match, used by every decode below
  function automatic logic addr_hit(
    input logic [SLX_ADDR_W-1:0] a,
    input logic [SLX_ADDR_W-1:0] off
  );
    addr_hit = (a == off);
  endfunction

  // Place two selects into a crossbar register image
  function automatic logic [7:0] map_image(
    input logic [2:0] lo,
    input logic [2:0] hi
  );
    map_image = {2'b00, hi, lo};
  endfunction

  // Pull one three-bit select out of a register image
  function automatic logic [2:0] sel_field(
    input logic [7:0] img,
    input int lsb
  );
    sel_field = img[lsb +: SLX_SEL_W];
  endfunction

  // Write-one-to-clear; the set side wins a same-cycle tie
  function automatic logic [7:0] w1c_next(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic clr_en,
    input logic [7:0] wd
  );
    w1c_next = (cur & ~({8{clr_en}} & wd)) | set;
  endfunction

  // Rising edge of a flag word against its previous sample
  function automatic logic [7:0] rise_of(
    input logic [7:0] flags,
    input logic [7:0] prev
  );
    rise_of = flags & ~prev;
  endfunction

  // Plain read/write register with a write enable
  function automatic logic [7:0] rw_next(
    input logic en,
    input logic [7:0] wd,
    input logic [7:0] cur
  );
    rw_next = en ? wd : cur;
  endfunction

  // Select registers
  logic [2:0] sel4_q;
  logic [2:0] sel4_d;
  logic [2:0] sel5_q;
  logic [2:0] sel5_d;
  logic [2:0] sel6_q;
  logic [2:0] sel6_d;
  logic [2:0] sel7_q;
  logic [2:0] sel7_d;

  // FIFO flag images
  logic [7:0] full_q;
  logic [7:0] empty_q;

  // Sticky events and their masks
  logic [7:0] full_evt_q;
  logic [7:0] full_evt_d;
  logic [7:0] empty_evt_q;
  logic [7:0] empty_evt_d;
  logic [7:0] full_mask_q;
  logic [7:0] full_mask_d;
  logic [7:0] empty_mask_q;
  logic [7:0] empty_mask_d;

  // Read path and interrupt
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;

  // Address decode
  logic hit_map45;
  logic hit_map67;
  logic hit_full;
  logic hit_empty;
  logic hit_fstat;
  logic hit_fmask;
  logic hit_estat;
  logic hit_emask;
  logic hit_any;

  assign hit_map45 = addr_hit(i_addr, SLX_MAP_FOUR_FIVE_ADDR);
  assign hit_map67 = addr_hit(i_addr, SLX_MAP_SIX_SEVEN_ADDR);
  assign hit_full = addr_hit(i_addr, SLX_FIFO_FULL_ADDR);
  assign hit_empty = addr_hit(i_addr, SLX_FIFO_EMPTY_ADDR);
  assign hit_fstat = addr_hit(i_addr, SLX_FULL_EVT_STAT_ADDR);
  assign hit_fmask = addr_hit(i_addr, SLX_FULL_EVT_MASK_ADDR);
  assign hit_estat = addr_hit(i_addr, SLX_EMPTY_EVT_STAT_ADDR);
  assign hit_emask = addr_hit(i_addr, SLX_EMPTY_EVT_MASK_ADDR);
  assign hit_any = hit_map45 | hit_map67 | hit_full | hit_empty |
                   hit_fstat | hit_fmask | hit_estat | hit_emask;

  // Write strobes per register
  logic wr_map45;
  logic wr_map67;
  logic wr_fstat;
  logic wr_fmask;
  logic wr_estat;
  logic wr_emask;

  assign wr_map45 = i_wr & hit_map45;
  assign wr_map67 = i_wr & hit_map67;
  assign wr_fstat = i_wr & hit_fstat;
  assign wr_fmask = i_wr & hit_fmask;
  assign wr_estat = i_wr & hit_estat;
  assign wr_emask = i_wr & hit_emask;

  // Crossbar selects; bits 7:6 of the write data are dropped
  assign sel4_d = wr_map45 ?
                  sel_field(i_wdata, SLX_LO_SEL_LSB) : sel4_q;
  assign sel5_d = wr_map45 ?
                  sel_field(i_wdata, SLX_HI_SEL_LSB) : sel5_q;
  assign sel6_d = wr_map67 ?
                  sel_field(i_wdata, SLX_LO_SEL_LSB) : sel6_q;
  assign sel7_d = wr_map67 ?
                  sel_field(i_wdata, SLX_HI_SEL_LSB) : sel7_q;

  // Lane four select comes up on physical input four
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel4_q <= SLX_SEL4_RST;
    end else begin
      sel4_q <= sel4_d;
    end
  end

  // Lane five select, identity mapping after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel5_q <= SLX_SEL5_RST;
    end else begin
      sel5_q <= sel5_d;
    end
  end

  // Lane six select, identity mapping after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel6_q <= SLX_SEL6_RST;
    end else begin
      sel6_q <= sel6_d;
    end
  end

  // Lane seven select, identity mapping after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel7_q <= SLX_SEL7_RST;
    end else begin
      sel7_q <= sel7_d;
    end
  end

  // Selects gathered for the lane generate, lane four first
  logic [2:0] sel_w [SLX_LOG_N];

  assign sel_w[0] = sel4_q;
  assign sel_w[1] = sel5_q;
  assign sel_w[2] = sel6_q;
  assign sel_w[3] = sel7_q;

  // One registered selector per logical lane
  for (genvar g = 0; g < SLX_LOG_N; g++) begin : g_lane
    slx_lane_mux #(
      .LANE_W(LANE_W)
    ) u_mux (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_sel(sel_w[g]),
      .i_data(i_phys_data),
      .i_valid(i_phys_valid),
      .o_data(o_log_data[g*LANE_W +: LANE_W]),
      .o_valid(o_log_valid[g])
    );
  end

  // FIFO flags are sampled once; the copy feeds reads and edge detect
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      full_q <= SLX_STAT_RST;
    end else begin
      full_q <= i_fifo_full;
    end
  end

  // Empty image; reads show the flags one cycle late
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      empty_q <= SLX_STAT_RST;
    end else begin
      empty_q <= i_fifo_empty;
    end
  end

  // Rising edges of the flags are the interrupt events
  logic [7:0] full_rise;
  logic [7:0] empty_rise;

  assign full_rise = rise_of(i_fifo_full, full_q);
  assign empty_rise = rise_of(i_fifo_empty, empty_q);

  // Write one to clear; a new event in the same cycle wins
  assign full_evt_d = w1c_next(full_evt_q, full_rise, wr_fstat, i_wdata);
  assign empty_evt_d = w1c_next(empty_evt_q, empty_rise, wr_estat, i_wdata);

  // Masks are plain read/write, one enables a bit onto the interrupt
  assign full_mask_d = rw_next(wr_fmask, i_wdata, full_mask_q);
  assign empty_mask_d = rw_next(wr_emask, i_wdata, empty_mask_q);

  // Full-rise events stay set until software clears them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      full_evt_q <= SLX_STAT_RST;
    end else begin
      full_evt_q <= full_evt_d;
    end
  end

  // Empty flags high at release raise an event on the first edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      empty_evt_q <= SLX_STAT_RST;
    end else begin
      empty_evt_q <= empty_evt_d;
    end
  end

  // Full-event mask, all disabled after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      full_mask_q <= SLX_MASK_RST;
    end else begin
      full_mask_q <= full_mask_d;
    end
  end

  // Empty-event mask, all disabled after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      empty_mask_q <= SLX_MASK_RST;
    end else begin
      empty_mask_q <= empty_mask_d;
    end
  end

  // Interrupt from next-state values so it tracks the status flops
  logic full_irq_w;
  logic empty_irq_w;

  assign full_irq_w = |(full_evt_d & full_mask_d);
  assign empty_irq_w = |(empty_evt_d & empty_mask_d);
  assign irq_d = full_irq_w | empty_irq_w;

  // Registered so the pin comes straight from a flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Register images of the two crossbar registers
  logic [7:0] map45_img;
  logic [7:0] map67_img;

  assign map45_img = map_image(sel4_q, sel5_q);
  assign map67_img = map_image(sel6_q, sel7_q);

  // Read selection; unmapped addresses and idle cycles read zero
  logic [7:0] rd_mux;

  assign rd_mux =
    hit_map45 ? map45_img :
    hit_map67 ? map67_img :
    hit_full ? full_q :
    hit_empty ? empty_q :
    hit_fstat ? full_evt_q :
    hit_fmask ? full_mask_q :
    hit_estat ? empty_evt_q :
    hit_emask ? empty_mask_q :
    SLX_RD_IDLE;

  // Data stand only in the cycle after the read strobe
  logic rd_take;

  assign rd_take = i_rd & hit_any;
  assign rdata_d = rd_take ? rd_mux : SLX_RD_IDLE;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= SLX_RD_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign o_rdata = rdata_q;
  assign o_irq = irq_q;

endmodule

// File: verif/slx_xbar_checker.sv
// Checker: routing, readback and status properties of the crossbar
module slx_xbar_checker
  import slx_pkg::*;
#(parameter int LANE_W = 32) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [8*LANE_W-1:0] i_phys_data,
  input wire logic [7:0] i_phys_valid,
  input wire logic [7:0] i_fifo_full,
  input wire logic [7:0] i_fifo_empty,
  input wire logic [4*LANE_W-1:0] o_log_data,
  input wire logic [3:0] o_log_valid
);
  logic [11:0] sel_q;
  logic [LANE_W:0] ex_q [4];
  logic [LANE_W:0] lg [4];
  // Shadow selects, lane seven in the top field
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) sel_q <= 12'hFAC;
    else if (i_wr && i_addr == SLX_MAP_FOUR_FIVE_ADDR)
      sel_q[5:0] <= i_wdata[5:0];
    else if (i_wr && i_addr == SLX_MAP_SIX_SEVEN_ADDR)
      sel_q[11:6] <= i_wdata[5:0];
  // Expected lane word, one cycle behind the inputs
  for (genvar k = 0; k < 4; k++) begin : g_ex
    assign lg[k] = {o_log_valid[k], o_log_data[k*LANE_W+:LANE_W]};
    always_ff @(posedge i_clk or negedge i_rst_n)
      if (!i_rst_n) ex_q[k] <= '0;
      else ex_q[k] <= {i_phys_valid[sel_q[3*k+:3]],
                       i_phys_data[sel_q[3*k+:3]*LANE_W+:LANE_W]};
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence rd_at(logic [11:0] a);
    i_rd && i_addr == a;
  endsequence
  lane_four_a: assert property (lg[0] == ex_q[0])
    else $error("lane four routing wrong");
  lane_five_a: assert property (lg[1] == ex_q[1])
    else $error("lane five routing wrong");
  lane_six_a: assert property (lg[2] == ex_q[2])
    else $error("lane six routing wrong");
  lane_seven_a: assert property (lg[3] == ex_q[3])
    else $error("lane seven routing wrong");
  map_four_a: assert property (
    rd_at(SLX_MAP_FOUR_FIVE_ADDR) |=> o_rdata == {2'b00, $past(sel_q[5:0])})
    else $error("lanes four five readback wrong");
  map_six_a: assert property (
    rd_at(SLX_MAP_SIX_SEVEN_ADDR) |=> o_rdata == {2'b00, $past(sel_q[11:6])})
    else $error("lanes six seven readback wrong");
  full_stat_a: assert property (
    rd_at(SLX_FIFO_FULL_ADDR) |=> o_rdata == $past(i_fifo_full, 2))
    else $error("full status readback wrong");
  empty_stat_a: assert property (
    rd_at(SLX_FIFO_EMPTY_ADDR) |=> o_rdata == $past(i_fifo_empty, 2))
    else $error("empty status readback wrong");
endmodule

bind slx_crossbar_upper slx_xbar_checker #(.LANE_W(LANE_W)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_phys_data(i_phys_data),
  .i_phys_valid(i_phys_valid), .i_fifo_full(i_fifo_full),
  .i_fifo_empty(i_fifo_empty), .o_log_data(o_log_data),
  .o_log_valid(o_log_valid));

// File: verif/slx_lane_src.sv
// Partner: eight-lane transmitter model feeding deserialised words
module slx_lane_src #(parameter int LANE_W = 32) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_stall,
  output logic [8*LANE_W-1:0] o_data,
  output logic [7:0] o_valid
);
  logic [15:0] cnt_q;
  // Words change every cycle so a late select shows up
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) cnt_q <= 16'h0000;
    else cnt_q <= cnt_q + 16'h0001;
  // Lane number in bits 23:16 keeps lanes apart; stall gaps valid
  for (genvar n = 0; n < 8; n++) begin : g_ln
    assign o_data[n*LANE_W+:LANE_W] = LANE_W'({8'(n), cnt_q});
    assign o_valid[n] = !i_stall || (cnt_q[0] != (n % 2 == 1));
  end
endmodule

// File: verif/tb.sv
// Testbench: register map, lane routing, FIFO status and interrupt
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import slx_pkg::*;
  localparam int W = 32;
  logic i_clk, i_rst_n, i_wr, i_rd, stall, o_irq;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_fifo_full, i_fifo_empty, pv, snap_v;
  logic [3:0] o_log_valid;
  logic [8*W-1:0] pd, snap_d;
  logic [4*W-1:0] o_log_data;
  int num_errors = 0;
  int total_checks = 0;
  slx_crossbar_upper #(.LANE_W(W)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_phys_data(pd), .i_phys_valid(pv),
    .i_fifo_full(i_fifo_full), .i_fifo_empty(i_fifo_empty),
    .o_log_data(o_log_data), .o_log_valid(o_log_valid), .o_irq(o_irq));
  slx_lane_src #(.LANE_W(W)) u_src (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_stall(stall), .o_data(pd), .o_valid(pv));
  // 40 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic final_report();
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_lane(input logic [W:0] got, input logic [W:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_lane((W+1)'(got), (W+1)'(exp));
  endtask
  // Bus cycles: strobes last one cycle, data read the cycle after
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk_reg(o_rdata, exp);
  endtask
  // Lane words sampled at the edge, outputs one cycle later
  task automatic lane_chk(input logic [11:0] sel);
    @(posedge i_clk);
    snap_d = pd;
    snap_v = pv;
    #1;
    for (int k = 0; k < 4; k++)
      chk_lane({o_log_valid[k], o_log_data[k*W+:W]},
               {snap_v[sel[3*k+:3]], snap_d[sel[3*k+:3]*W+:W]});
  endtask
  task automatic irq_chk(input logic exp);
    #1 chk_reg({7'h00, o_irq}, {7'h00, exp});
  endtask
  task automatic t_reset();
    rd_chk(SLX_MAP_FOUR_FIVE_ADDR, 8'h2C);
    rd_chk(SLX_MAP_SIX_SEVEN_ADDR, 8'h3E);
    rd_chk(SLX_FIFO_FULL_ADDR, 8'h00);
    rd_chk(SLX_FIFO_EMPTY_ADDR, 8'h00);
    lane_chk(12'hFAC);
  endtask
  // Every code on every lane, reserved bits written as ones
  task automatic t_routes();
    logic [2:0] a, b, c, d;
    for (int v = 0; v < 8; v++) begin
      a = 3'(v);
      b = 3'(7 - v);
      c = 3'(v + 3);
      d = 3'(v + 5);
      stall <= v[0];
      wr(SLX_MAP_FOUR_FIVE_ADDR, {2'b11, b, a});
      wr(SLX_MAP_SIX_SEVEN_ADDR, {2'b11, d, c});
      lane_chk({d, c, b, a});
      rd_chk(SLX_MAP_FOUR_FIVE_ADDR, {2'b00, b, a});
      rd_chk(SLX_MAP_SIX_SEVEN_ADDR, {2'b00, d, c});
    end
    rd_chk(12'h300, 8'h00);
  endtask
  // Status follows flags; writes to it are dropped
  task automatic t_status();
    i_fifo_full <= 8'hA5;
    i_fifo_empty <= 8'h5A;
    wr(SLX_FIFO_FULL_ADDR, 8'h00);
    rd_chk(SLX_FIFO_FULL_ADDR, 8'hA5);
    rd_chk(SLX_FIFO_EMPTY_ADDR, 8'h5A);
  endtask
  // Raise, mask and clear the full-rise interrupt
  task automatic t_irq();
    wr(SLX_FULL_EVT_MASK_ADDR, 8'h04);
    irq_chk(1'b1);
    rd_chk(SLX_FULL_EVT_STAT_ADDR, 8'hA5);
    wr(SLX_FULL_EVT_STAT_ADDR, 8'hA5);
    irq_chk(1'b0);
    i_fifo_full <= 8'hA7;
    wr(SLX_FULL_EVT_STAT_ADDR, 8'h00);
    irq_chk(1'b0);
    rd_chk(SLX_FULL_EVT_STAT_ADDR, 8'h02);
    i_fifo_full <= 8'h00;
    @(posedge i_clk);
    i_fifo_full <= 8'h04;
    @(posedge i_clk);
    irq_chk(1'b1);
    wr(SLX_FULL_EVT_MASK_ADDR, 8'h00);
    irq_chk(1'b0);
  endtask
  // Empty-rise events, their mask, and a set beating a clear
  task automatic t_empty();
    rd_chk(SLX_EMPTY_EVT_STAT_ADDR, 8'h5A);
    wr(SLX_EMPTY_EVT_MASK_ADDR, 8'h08);
    irq_chk(1'b1);
    @(posedge i_clk);
    i_addr <= SLX_EMPTY_EVT_STAT_ADDR;
    i_wdata <= 8'h09;
    i_wr <= 1'b1;
    i_fifo_empty <= 8'h5B;
    @(posedge i_clk);
    i_wr <= 1'b0;
    irq_chk(1'b0);
    rd_chk(SLX_EMPTY_EVT_STAT_ADDR, 8'h53);
    wr(SLX_EMPTY_EVT_MASK_ADDR, 8'h01);
    irq_chk(1'b1);
    rd_chk(SLX_EMPTY_EVT_MASK_ADDR, 8'h01);
    wr(SLX_EMPTY_EVT_STAT_ADDR, 8'hFF);
    irq_chk(1'b0);
    rd_chk(SLX_EMPTY_EVT_STAT_ADDR, 8'h00);
  endtask
  // Mid-run reset brings back the map, status, full mask and full event reset values
  task automatic t_rerst();
    wr(SLX_FULL_EVT_MASK_ADDR, 8'hFF);
    irq_chk(1'b1);
    i_fifo_full <= 8'h00;
    i_fifo_empty <= 8'h00;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    rd_chk(SLX_FULL_EVT_MASK_ADDR, 8'h00);
    rd_chk(SLX_FULL_EVT_STAT_ADDR, 8'h00);
    irq_chk(1'b0);
  endtask
  // Run takes under a thousand cycles
  initial begin
    #(5000 * 25);
    num_errors++;
    final_report();
  end
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 8'h00;
    i_fifo_full = 8'h00;
    i_fifo_empty = 8'h00;
    stall = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_routes();
    t_status();
    t_irq();
    t_empty();
    t_rerst();
    final_report();
  end
endmodule
